// >>> rxes_pkg.sv
`default_nettype none
package rxes_pkg;
  // Register index as printed; byte address is four times it
  localparam logic [7:0]  SEQ_CFG2_IDX     = 8'h37;
  localparam logic [11:0] SEQ_CFG2_ADDR    = 12'h0DC;
  localparam logic [11:0] STATUS_ADDR      = 12'h100;
  localparam logic [11:0] IRQ_EN_ADDR      = 12'h104;
  localparam logic [11:0] IRQ_CLR_ADDR     = 12'h108;
  localparam logic [11:0] CTRL_ADDR        = 12'h10C;
  localparam logic [7:0]  SEQ_CFG2_RESET   = 8'h00;
  localparam int          RX_SEL_HI        = 7;
  localparam int          RX_SEL_LO        = 5;
  localparam int          TO_SEL_HI        = 4;
  localparam int          TO_SEL_LO        = 3;
  localparam logic [2:0]  RX_SEL_UNUSED0   = 3'h0;
  localparam logic [2:0]  RX_SEL_PAYLOAD   = 3'h1;
  localparam logic [2:0]  RX_SEL_PAYLOAD_LP = 3'h2;
  localparam logic [2:0]  RX_SEL_CHECKSUM  = 3'h3;
  localparam logic [2:0]  RX_SEL_LEVEL     = 3'h4;
  localparam logic [2:0]  RX_SEL_SYNC      = 3'h5;
  localparam logic [2:0]  RX_SEL_PREAMBLE  = 3'h6;
  localparam logic [2:0]  RX_SEL_UNUSED7   = 3'h7;
  localparam logic [1:0]  TO_SEL_RESTART   = 2'h0;
  localparam logic [1:0]  TO_SEL_TRANSMIT  = 2'h1;
  localparam logic [1:0]  TO_SEL_LOWPOWER  = 2'h2;
  localparam logic [1:0]  TO_SEL_IDLE      = 2'h3;
  // Status bit positions
  localparam int          ST_EXIT          = 0;
  localparam int          ST_TIMEOUT       = 1;
  localparam int          ST_RESTART       = 2;
  localparam int          ST_WIDTH         = 3;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;

  typedef enum logic [5:0] {
    RXES_ST_IDLE     = 6'b000001,
    RXES_ST_RECEIVE  = 6'b000010,
    RXES_ST_PKT_DONE = 6'b000100,
    RXES_ST_LOW_PWR  = 6'b001000,
    RXES_ST_TRANSMIT = 6'b010000,
    RXES_ST_SEQ_IDLE = 6'b100000
  } rxes_state_type;
endpackage
`default_nettype wire

// >>> rxes_top.sv
// Overview of operation
// (R1) Bits 7..5 select how the sequencer leaves Receive.
// (R2) Receive-exit codes 000 and 111 have no exit event.
// (R3) Code 001: payload complete moves Receive to packet-done.
// (R4) Code 010: payload complete moves Receive to low-power choice.
// (R5) Code 011: checksum pass moves Receive to packet-done.
// (R6) Code 100: signal level moves Receive to sequencer-idle.
// (R7) Code 101: sync match moves Receive to sequencer-idle.
// (R8) Code 110: preamble seen moves Receive to sequencer-idle.
// (R9) Bits 4..3 steer timeout exit, and payload complete under 011.
// (R10) Timeout code 00: stay in Receive via receiver restart.
// (R11) Timeout code 01: go to Transmit.
// (R12) Timeout code 10: low-power choice; code 11: sequencer-idle.
// (R13) Receive timeout is any of level, preamble or sync wait timeouts.
// (R14) Receive holds until selected event or receive timeout.
//
// Chosen here: the AXI4-Lite register port.
`default_nettype none
module rxes_top
  import rxes_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Receive events, one-cycle pulses from same-clock logic
  input  wire logic        payload_complete_flag,
  input  wire logic        checksum_pass_flag,
  input  wire logic        level_flag,
  input  wire logic        sync_match_flag,
  input  wire logic        preamble_seen_flag,
  input  wire logic        level_wait_timeout,
  input  wire logic        preamble_wait_timeout,
  input  wire logic        sync_wait_timeout,
  // Sequencer view
  output logic [5:0]       seq_state,
  output logic             receive_timeout_flag,
  output logic             receiver_restart,
  output logic             irq
);

  logic [7:0]          cfg_reg;
  logic                start_reg;
  logic                stop_reg;
  logic [ST_WIDTH-1:0] status_reg;
  logic [ST_WIDTH-1:0] irq_en_reg;
  rxes_state_type      state_reg;
  rxes_state_type      state_next;
  logic                restart_reg;
  logic                timeout_reg;
  logic [2:0]          rx_exit_select;
  logic [1:0]          timeout_exit_select;
  logic                rx_timeout;
  logic                exit_event;
  logic                to_event;
  logic                restart_now;
  logic                aw_held;
  logic                w_held;
  logic [11:0]         aw_addr_reg;
  logic [31:0]         w_data_reg;
  logic [3:0]          w_strb_reg;
  logic                wr_go;
  logic                rd_go;
  logic [31:0]         rd_word;
  logic                rd_hit;
  logic                wr_hit;
  logic [ST_WIDTH-1:0] status_set;
  logic                status_clr;

  assign rx_exit_select      = cfg_reg[RX_SEL_HI:RX_SEL_LO]; // R1
  assign timeout_exit_select = cfg_reg[TO_SEL_HI:TO_SEL_LO]; // R9

  assign rx_timeout = level_wait_timeout | preamble_wait_timeout | sync_wait_timeout; // R13

  // Exit event chosen by the receive-exit field
  always_comb
  begin
    exit_event = 1'b0;
    to_event   = rx_timeout;
    unique case (rx_exit_select)
      RX_SEL_PAYLOAD:    exit_event = payload_complete_flag; // R3
      RX_SEL_PAYLOAD_LP: exit_event = payload_complete_flag; // R4
      RX_SEL_CHECKSUM:
      begin
        exit_event = checksum_pass_flag; // R5
        to_event   = rx_timeout | (payload_complete_flag & ~checksum_pass_flag); // R9
      end
      RX_SEL_LEVEL:      exit_event = level_flag; // R6
      RX_SEL_SYNC:       exit_event = sync_match_flag; // R7
      RX_SEL_PREAMBLE:   exit_event = preamble_seen_flag; // R8
      RX_SEL_UNUSED0,
      RX_SEL_UNUSED7:    exit_event = 1'b0; // R2
    endcase
  end

  // Next state; the selected event beats a timeout arriving in the same cycle
  always_comb
  begin
    state_next  = state_reg;
    restart_now = 1'b0;
    unique case (state_reg)
      RXES_ST_IDLE:
        if (start_reg)
          state_next = RXES_ST_RECEIVE;
      RXES_ST_RECEIVE:
        if (stop_reg)
          state_next = RXES_ST_IDLE;
        else if (exit_event)
        begin
          unique case (rx_exit_select)
            RX_SEL_PAYLOAD,
            RX_SEL_CHECKSUM:   state_next = RXES_ST_PKT_DONE; // R3 R5
            RX_SEL_PAYLOAD_LP: state_next = RXES_ST_LOW_PWR; // R4
            default:           state_next = RXES_ST_SEQ_IDLE; // R6 R7 R8
          endcase
        end
        else if (to_event)
        begin
          unique case (timeout_exit_select)
            TO_SEL_RESTART:  restart_now = 1'b1; // R10
            TO_SEL_TRANSMIT: state_next = RXES_ST_TRANSMIT; // R11
            TO_SEL_LOWPOWER: state_next = RXES_ST_LOW_PWR; // R12
            TO_SEL_IDLE:     state_next = RXES_ST_SEQ_IDLE; // R12
          endcase
        end
      RXES_ST_PKT_DONE,
      RXES_ST_LOW_PWR,
      RXES_ST_TRANSMIT,
      RXES_ST_SEQ_IDLE:
        if (stop_reg)
          state_next = RXES_ST_IDLE;
      default:
        state_next = RXES_ST_IDLE;
    endcase
  end

  // Receive otherwise holds until an exit or timeout
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= RXES_ST_IDLE;
    else
      state_reg <= state_next; // R14
  end

  // Restart pulse, one cycle after a timeout handled in place
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      restart_reg <= 1'b0;
    else
      restart_reg <= restart_now; // R10
  end

  // Timeout pulse is flagged even when an exit event wins the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timeout_reg <= 1'b0;
    else
      timeout_reg <= (state_reg == RXES_ST_RECEIVE) & rx_timeout; // R13
  end

  assign seq_state            = state_reg;
  assign receiver_restart     = restart_reg;
  assign receive_timeout_flag = timeout_reg;

  // AXI4-Lite write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_go         = aw_held & w_held & ~s_axi_bvalid;
  assign wr_hit        = (aw_addr_reg == SEQ_CFG2_ADDR) | (aw_addr_reg == IRQ_EN_ADDR)
                       | (aw_addr_reg == IRQ_CLR_ADDR) | (aw_addr_reg == CTRL_ADDR);

  // Write address capture; ready stays low while held, so no overwrite
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held     <= 1'b0;
      aw_addr_reg <= 12'h000;
    end
    else if (wr_go)
      aw_held <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held     <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[11:2], 2'b00};
    end
  end

  // Write data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held     <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (wr_go)
      w_held <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held     <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end
  end

  // Write response; stands until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Configuration and control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg    <= SEQ_CFG2_RESET;
      irq_en_reg <= '0;
    end
    else if (wr_go && w_strb_reg[0])
    begin
      if (aw_addr_reg == SEQ_CFG2_ADDR)
        cfg_reg <= w_data_reg[7:0];
      if (aw_addr_reg == IRQ_EN_ADDR)
        irq_en_reg <= w_data_reg[ST_WIDTH-1:0];
    end
  end

  // Start and stop are one-cycle strobes, so a later write cannot replay them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end
    else if (wr_go && w_strb_reg[0] && aw_addr_reg == CTRL_ADDR)
    begin
      start_reg <= w_data_reg[0];
      stop_reg  <= w_data_reg[1];
    end
    else
    begin
      start_reg <= 1'b0;
      stop_reg  <= 1'b0;
    end
  end

  // Status events; an exit overridden by stop is not reported
  assign status_set = {restart_now,
                       (state_reg == RXES_ST_RECEIVE) & rx_timeout,
                       (state_reg == RXES_ST_RECEIVE) & exit_event & ~stop_reg};
  assign status_clr = wr_go & w_strb_reg[0] & (aw_addr_reg == IRQ_CLR_ADDR);

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      status_reg <= '0;
    else if (status_clr)
      status_reg <= (status_reg & ~w_data_reg[ST_WIDTH-1:0]) | status_set;
    else
      status_reg <= status_reg | status_set;
  end

  assign irq = |(status_reg & irq_en_reg);

  // AXI4-Lite read channel
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go         = s_axi_arvalid & s_axi_arready;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    unique case ({s_axi_araddr[11:2], 2'b00})
      SEQ_CFG2_ADDR: rd_word = {24'h000000, cfg_reg};
      STATUS_ADDR:   rd_word = {29'h0000_0000, status_reg};
      IRQ_EN_ADDR:   rd_word = {29'h0000_0000, irq_en_reg};
      IRQ_CLR_ADDR:  rd_word = 32'h0000_0000;
      CTRL_ADDR:     rd_word = {26'h000_0000, state_reg};
      default:       rd_hit  = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_rvalid <= 1'b0;
    else if (rd_go)
      s_axi_rvalid <= 1'b1;
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Data load only on acceptance, so it stands until the master takes it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

endmodule
`default_nettype wire

// >>> rxes_top_sva.sv
`default_nettype none
module rxes_top_sva
  import rxes_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Write traffic
  input wire logic [11:0] s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  // Events
  input wire logic        payload_complete_flag,
  input wire logic        checksum_pass_flag,
  input wire logic        level_flag,
  input wire logic        sync_match_flag,
  input wire logic        preamble_seen_flag,
  input wire logic        level_wait_timeout,
  input wire logic        preamble_wait_timeout,
  input wire logic        sync_wait_timeout,
  // Sequencer
  input wire logic [5:0]  seq_state,
  input wire logic        receive_timeout_flag,
  input wire logic        receiver_restart
);
  logic [7:0] cfg_reg;
  logic [1:0] busy_reg;
  logic [2:0] rs;
  logic [1:0] ts;
  logic [5:0] ev_state;
  logic       busy, in_rx, to_any, ev_sel, to_cause;
  // Writes may move the state, so judge only quiet cycles
  assign busy = s_axi_awvalid | s_axi_wvalid | s_axi_bvalid;
  assign in_rx = seq_state == RXES_ST_RECEIVE && !busy && busy_reg == 2'h0;
  assign rs = cfg_reg[7:5];
  assign ts = cfg_reg[4:3];
  assign to_any = level_wait_timeout | preamble_wait_timeout | sync_wait_timeout;
  assign ev_sel = (rs == RX_SEL_PAYLOAD || rs == RX_SEL_PAYLOAD_LP) && payload_complete_flag
    || rs == RX_SEL_CHECKSUM && checksum_pass_flag || rs == RX_SEL_LEVEL && level_flag
    || rs == RX_SEL_SYNC && sync_match_flag || rs == RX_SEL_PREAMBLE && preamble_seen_flag;
  assign ev_state = rs == RX_SEL_PAYLOAD_LP ? RXES_ST_LOW_PWR :
    rs[2] ? RXES_ST_SEQ_IDLE : RXES_ST_PKT_DONE;
  assign to_cause = to_any || rs == RX_SEL_CHECKSUM && payload_complete_flag;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg <= SEQ_CFG2_RESET;
      busy_reg <= 2'h0;
    end
    else
    begin
      busy_reg <= {busy_reg[0], busy};
      if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
          && s_axi_awaddr == SEQ_CFG2_ADDR && s_axi_wstrb[0])
        cfg_reg <= s_axi_wdata[7:0];
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  exit_event_a: assert property (in_rx && ev_sel |=> seq_state == $past(ev_state))
    else $error("selected exit event not taken");
  hold_receive_a: assert property (in_rx && !ev_sel && !to_cause |=> seq_state == RXES_ST_RECEIVE)
    else $error("receive left without cause");
  restart_stay_a: assert property (in_rx && !ev_sel && to_cause && ts == TO_SEL_RESTART
    |=> seq_state == RXES_ST_RECEIVE && receiver_restart) else $error("restart exit wrong");
  timeout_tx_a: assert property (in_rx && !ev_sel && to_cause && ts == TO_SEL_TRANSMIT
    |=> seq_state == RXES_ST_TRANSMIT) else $error("timeout to transmit missed");
  timeout_low_a: assert property (in_rx && !ev_sel && to_cause && ts == TO_SEL_LOWPOWER
    |=> seq_state == RXES_ST_LOW_PWR) else $error("timeout to low power missed");
  timeout_idle_a: assert property (in_rx && !ev_sel && to_cause && ts == TO_SEL_IDLE
    |=> seq_state == RXES_ST_SEQ_IDLE) else $error("timeout to idle missed");
  timeout_flag_a: assert property (in_rx && !ev_sel && to_any |=> receive_timeout_flag)
    else $error("receive timeout not flagged");
  timeout_cause_a: assert property (receive_timeout_flag
    |-> $past(to_any) && $past(seq_state) == RXES_ST_RECEIVE) else $error("spurious timeout");
  restart_in_rx_a: assert property (receiver_restart |-> seq_state == RXES_ST_RECEIVE)
    else $error("restart outside receive");
endmodule
bind rxes_top rxes_top_sva chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .payload_complete_flag, .checksum_pass_flag, .level_flag, .sync_match_flag,
  .preamble_seen_flag, .level_wait_timeout, .preamble_wait_timeout, .sync_wait_timeout,
  .seq_state, .receive_timeout_flag, .receiver_restart);
`default_nettype wire

// >>> test_rx_state_exit_sequencer.sv
`default_nettype none
module test_rx_state_exit_sequencer
  import rxes_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] cfg; logic [7:0] ev; logic [5:0] st; logic [1:0] fl;} rxes_row_type;
  logic         aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic         s_axi_rready, receive_timeout_flag, receiver_restart, irq;
  logic [11:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
  logic [7:0]   ev;
  logic [5:0]   seq_state;
  int           fails, n_compared;
  rxes_row_type rows [14];
  always #10 aclk = ~aclk;
  // Event bits, low to high: payload, checksum, level, sync, preamble, three timeouts
  rxes_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .payload_complete_flag(ev[0]), .checksum_pass_flag(ev[1]),
    .level_flag(ev[2]), .sync_match_flag(ev[3]), .preamble_seen_flag(ev[4]),
    .level_wait_timeout(ev[5]), .preamble_wait_timeout(ev[6]), .sync_wait_timeout(ev[7]),
    .seq_state, .receive_timeout_flag, .receiver_restart, .irq);
  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task finish_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Ready is sampled mid-cycle, so the handshake lands at the following edge
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!tb)
    begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [11:0] a);
    logic ta, tr;
    tr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!tr)
    begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic run_row(input rxes_row_type r);
    axi_wr(SEQ_CFG2_ADDR, {24'h0, r.cfg});
    axi_wr(CTRL_ADDR, 32'h2);
    axi_wr(CTRL_ADDR, 32'h1);
    repeat (3) @(posedge aclk);
    check("enter receive", RXES_ST_RECEIVE, seq_state);
    ev <= r.ev;
    @(posedge aclk);
    ev <= 8'h00;
    #1;
    check("next state", r.st, seq_state);
    check("pulses", r.fl, {receive_timeout_flag, receiver_restart});
    @(posedge aclk);
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    finish_test();
  end
  initial
  begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ev} = 64'h0;
    s_axi_wstrb = 4'hF;
    rows = '{'{8'h20, 8'h01, RXES_ST_PKT_DONE, 2'h0}, '{8'h40, 8'h01, RXES_ST_LOW_PWR, 2'h0},
      '{8'h60, 8'h02, RXES_ST_PKT_DONE, 2'h0}, '{8'h68, 8'h01, RXES_ST_TRANSMIT, 2'h0},
      '{8'h80, 8'h04, RXES_ST_SEQ_IDLE, 2'h0}, '{8'hA0, 8'h08, RXES_ST_SEQ_IDLE, 2'h0},
      '{8'hC0, 8'h10, RXES_ST_SEQ_IDLE, 2'h0}, '{8'h20, 8'h1E, RXES_ST_RECEIVE, 2'h0},
      '{8'h00, 8'h1F, RXES_ST_RECEIVE, 2'h0}, '{8'hE0, 8'h1F, RXES_ST_RECEIVE, 2'h0},
      '{8'h00, 8'h20, RXES_ST_RECEIVE, 2'h3}, '{8'h08, 8'h40, RXES_ST_TRANSMIT, 2'h2},
      '{8'h10, 8'h80, RXES_ST_LOW_PWR, 2'h2}, '{8'h18, 8'h20, RXES_ST_SEQ_IDLE, 2'h2}};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(SEQ_CFG2_ADDR);
    check("config reset", {24'h0, SEQ_CFG2_RESET}, rd);
    foreach (rows[i])
    begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    check("irq masked", 32'h0, irq);
    axi_wr(IRQ_EN_ADDR, 32'h7);
    check("irq raised", 32'h1, irq);
    axi_rd(STATUS_ADDR);
    check("status", 32'h7, rd);
    axi_wr(IRQ_CLR_ADDR, 32'h7);
    check("irq cleared", 32'h0, irq);
    $display("interrupt test done");
    axi_wr(12'h200, 32'hFFFF_FFFF);
    check("unmapped write", RESP_SLVERR, resp);
    axi_rd(12'h200);
    check("unmapped read", RESP_SLVERR, resp);
    axi_wr(SEQ_CFG2_ADDR, 32'hFFFF_FFFF);
    axi_rd(SEQ_CFG2_ADDR);
    check("config width", 32'h0000_00FF, rd);
    $display("register test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check("state after reset", RXES_ST_IDLE, seq_state);
    axi_rd(SEQ_CFG2_ADDR);
    check("config after reset", {24'h0, SEQ_CFG2_RESET}, rd);
    $display("second reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
